// ===== design/mssp_regs.svh
/*
 * mssp_regs.svh - timing counts, widths and reset values of the motor
 * start/stop sequencer and its position store.
 * assumes: included by design files only; clk_sys runs at 200 MHz.
 */
`ifndef MSSP_REGS_SVH
`define MSSP_REGS_SVH

// ----------------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------------
`define MSSP_CLK_HZ          200000000
`define MSSP_STORE_DELAY_S   5
`define MSSP_STORE_DELAY_CYC (`MSSP_STORE_DELAY_S * `MSSP_CLK_HZ)
`define MSSP_RAMP_MS_DEF     100
`define MSSP_CYC_PER_MS      (`MSSP_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define MSSP_POS_W           32
`define MSSP_SPD_W           16
`define MSSP_POS_RST         32'h0000_0000
`define MSSP_SPD_RST         16'h0000

`endif

// ===== design/mssp_pkg.sv
/*
 * mssp_pkg.sv - types shared by the motor sequencer files.
 * assumes: mssp_regs.svh is on the include path.
 */
`include "mssp_regs.svh"

package mssp_pkg;

    // ------------------------------------------------------------------
    // motor sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MSSP_ST_RESTORE = 3'b000,
        MSSP_ST_STOPPED = 3'b001,
        MSSP_ST_RAMP    = 3'b010,
        MSSP_ST_HOLD    = 3'b011,
        MSSP_ST_SHUTDN  = 3'b100,
        MSSP_ST_OFF     = 3'b101
    } mssp_state_e;

    // ------------------------------------------------------------------
    // drive command to the power stage
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     enable;
        logic                     forward_direction;
        logic [`MSSP_SPD_W-1:0]   speed;
    } mssp_drive_s;

    // ------------------------------------------------------------------
    // nonvolatile memory write request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     wr;
        logic [`MSSP_POS_W-1:0]   data;
    } mssp_nvm_wr_s;

endpackage

// ===== design/mssp_ramp.sv
/*
 * mssp_ramp.sv - linear speed ramp from zero up to a target speed.
 * assumes: start is a one-cycle pulse; clear forces speed to zero now.
 */
`timescale 1ns/1ps
`include "mssp_regs.svh"

module mssp_ramp
    import mssp_pkg::*;
#(
    parameter int RAMP_MS = `MSSP_RAMP_MS_DEF
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // control
    input  wire logic                   start,
    input  wire logic                   clear,
    input  wire logic [`MSSP_SPD_W-1:0] target,
    // result
    output logic [`MSSP_SPD_W-1:0]      speed,
    output logic                        done
);

    // ------------------------------------------------------------------
    // step timing: one speed unit per tick, whole ramp in RAMP_MS
    // ------------------------------------------------------------------
    localparam longint RAMP_CYC = longint'(RAMP_MS) * `MSSP_CYC_PER_MS;

    logic [31:0]              tick_q;
    logic [31:0]              tick_len_q;
    logic [`MSSP_SPD_W-1:0]   speed_q;
    logic                     run_q;
    logic                     done_q;
    wire                      tick_end = (tick_q + 32'h1 >= tick_len_q);
    wire                      at_top   = (speed_q >= target);
    wire [31:0]               len_calc;

    assign len_calc = (target == `MSSP_SPD_RST) ? 32'h1 :
        32'(RAMP_CYC / longint'(target));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_q     <= 32'h0;
            tick_len_q <= 32'h1;
            speed_q    <= `MSSP_SPD_RST;
            run_q      <= 1'b0;
            done_q     <= 1'b0;
        end else if (clear) begin
            tick_q  <= 32'h0;
            speed_q <= `MSSP_SPD_RST;
            run_q   <= 1'b0;
            done_q  <= 1'b0;
        end else if (start) begin
            // ramp always begins from standstill
            tick_q     <= 32'h0;
            tick_len_q <= (len_calc == 32'h0) ? 32'h1 : len_calc;
            speed_q    <= `MSSP_SPD_RST;
            run_q      <= 1'b1;
            done_q     <= 1'b0;
        end else if (run_q) begin
            if (at_top) begin
                run_q  <= 1'b0;
                done_q <= 1'b1;
            end else if (tick_end) begin
                tick_q  <= 32'h0;
                speed_q <= speed_q + 16'h1;
            end else begin
                tick_q <= tick_q + 32'h1;
            end
        end
    end

    assign speed = speed_q;
    assign done  = done_q;

endmodule

// ===== design/mssp_seq.sv
/*
 * mssp_seq.sv - start/stop/restart sequencer of a DC motor with linear
 * acceleration and a nonvolatile store of the last reached position.
 * assumes: run, direction and shutdown requests come from pins; position
 * counts come from the encoder logic on clk_sys; the memory takes one
 * write pulse and answers with a done pulse; the restore value is valid
 * while restore_valid is high after reset.
 */
// How it works
// - run dropping to stop halts the drive at once, no deceleration ramp.
// - run back to start restarts in selected direction with a ramp.
// - after the ramp the drive holds the commanded speed.
// - start with opposite direction runs a fresh ramp that way, then holds.
// - five seconds into stop, store position if it differs from stored.
// - shutdown stores the present position even when the motor runs.
// - on shutdown with motor running, stop first, then commit position.
// - at power-up load the position counter from the stored value.
// - reversible mode: reacquire limits, no standby, stay in start.
// - ramps change speed linearly, durations set in milliseconds.
`timescale 1ns/1ps
`include "mssp_regs.svh"

module mssp_seq
    import mssp_pkg::*;
#(
    parameter int              RAMP_MS     = `MSSP_RAMP_MS_DEF,
    parameter longint unsigned STORE_DELAY = `MSSP_STORE_DELAY_CYC
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // command pins
    input  wire logic                   run_cmd,
    input  wire logic                   forward_direction,
    input  wire logic                   shutdown_req,
    input  wire logic                   reversible_mode,
    // speed setpoint and encoder position (same clock)
    input  wire logic [`MSSP_SPD_W-1:0] speed_set,
    input  wire logic                   pos_step,
    input  wire logic                   pos_up,
    // nonvolatile memory
    input  wire logic [`MSSP_POS_W-1:0] restore_data,
    input  wire logic                   restore_valid,
    input  wire logic                   nvm_done,
    output mssp_nvm_wr_s                nvm_wr,
    // drive stage and status
    output mssp_drive_s                 drive,
    output logic [`MSSP_POS_W-1:0]      position,
    output logic                        limit_acquire,
    output logic                        standby_allowed,
    output logic                        off_ready
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pin_m_q;
    logic [3:0] pin_s_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_m_q <= 4'h0;
            pin_s_q <= 4'h0;
        end else begin
            pin_m_q <= {reversible_mode, shutdown_req, forward_direction,
                        run_cmd};
            pin_s_q <= pin_m_q;
        end
    end

    wire run_s   = pin_s_q[0];
    wire fwd_s   = pin_s_q[1];
    wire shut_s  = pin_s_q[2];
    wire rev_s   = pin_s_q[3];

    // ------------------------------------------------------------------
    // state and stored values
    // ------------------------------------------------------------------
    mssp_state_e              state_q;
    mssp_state_e              state_d;
    logic                     run_prev_q;
    logic                     dir_q;
    logic [`MSSP_POS_W-1:0]   pos_q;
    logic [`MSSP_POS_W-1:0]   stored_q;
    logic [63:0]              wait_q;
    logic                     wait_on_q;
    logic                     wr_q;
    logic                     wr_busy_q;
    logic                     shut_wr_q;
    logic                     stby_q;
    logic                     acq_q;
    logic                     rev_cap_q;
    logic                     off_q;
    mssp_drive_s              drive_q;
    logic [`MSSP_SPD_W-1:0]   ramp_speed;
    logic                     ramp_done;

    // reversible mode forces run permanently on
    wire run_eff    = run_s | rev_cap_q;
    wire run_rise   = run_eff & ~run_prev_q;
    wire dir_change = run_eff & (fwd_s != dir_q);
    wire moving     = (state_q == MSSP_ST_RAMP) |
                      (state_q == MSSP_ST_HOLD);
    wire ramp_start = (state_q == MSSP_ST_STOPPED & run_rise) |
                      (moving & dir_change);
    wire ramp_clear = (moving & ~run_eff) | shut_s;
    wire wait_hit   = wait_on_q & (wait_q + 64'h1 >= STORE_DELAY);
    wire pos_differs = (pos_q != stored_q);
    // a start in the same cycle wins over the timed store
    wire store_5s   = wait_hit & pos_differs & ~wr_busy_q &
                      ~ramp_start;
    wire store_off  = (state_q == MSSP_ST_SHUTDN) & ~wr_busy_q &
                      ~wr_q & (drive_q.speed == `MSSP_SPD_RST);
    wire wr_fire    = store_5s | store_off;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MSSP_ST_RESTORE: if (restore_valid) state_d = MSSP_ST_STOPPED;
            MSSP_ST_STOPPED: begin
                if (shut_s) state_d = MSSP_ST_SHUTDN;
                else if (run_rise) state_d = MSSP_ST_RAMP;
            end
            MSSP_ST_RAMP, MSSP_ST_HOLD: begin
                if (shut_s) state_d = MSSP_ST_SHUTDN;
                else if (!run_eff) state_d = MSSP_ST_STOPPED;
                else if (dir_change) state_d = MSSP_ST_RAMP;
                else if (ramp_done) state_d = MSSP_ST_HOLD;
            end
            // only the shutdown store itself may release to off
            MSSP_ST_SHUTDN: if (shut_wr_q && wr_busy_q && nvm_done)
                state_d = MSSP_ST_OFF;
            MSSP_ST_OFF: state_d = MSSP_ST_OFF;
        endcase
    end

    // ------------------------------------------------------------------
    // sequencing registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= MSSP_ST_RESTORE;
            run_prev_q <= 1'b0;
            dir_q      <= 1'b0;
            rev_cap_q  <= 1'b0;
            stby_q     <= 1'b0;
            acq_q      <= 1'b0;
            off_q      <= 1'b0;
        end else begin
            state_q    <= state_d;
            run_prev_q <= run_eff;
            if (ramp_start) dir_q <= fwd_s;
            if (state_q == MSSP_ST_RESTORE && restore_valid) begin
                rev_cap_q <= rev_s;
                stby_q    <= ~rev_s;
                acq_q     <= rev_s;
            end else if (state_q == MSSP_ST_HOLD) begin
                acq_q <= 1'b0;
            end
            off_q <= (state_d == MSSP_ST_OFF);
        end
    end

    // ------------------------------------------------------------------
    // position counter, restored at power-up
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pos_q    <= `MSSP_POS_RST;
            stored_q <= `MSSP_POS_RST;
        end else if (state_q == MSSP_ST_RESTORE) begin
            if (restore_valid) begin
                pos_q    <= restore_data;
                stored_q <= restore_data;
            end
        end else begin
            if (pos_step) pos_q <= pos_up ? pos_q + 32'h1 : pos_q - 32'h1;
            if (wr_fire) stored_q <= pos_q;
        end
    end

    // ------------------------------------------------------------------
    // five second store timer and memory write
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q    <= 64'h0;
            wait_on_q <= 1'b0;
            wr_q      <= 1'b0;
            wr_busy_q <= 1'b0;
            shut_wr_q <= 1'b0;
        end else begin
            if (store_off) shut_wr_q <= 1'b1;
            if (ramp_start || state_q != MSSP_ST_STOPPED) begin
                wait_on_q <= 1'b0;
                wait_q    <= 64'h0;
            end else if (state_q == MSSP_ST_STOPPED && wait_hit) begin
                wait_on_q <= 1'b0;
            end else if (wait_on_q) begin
                wait_q <= wait_q + 64'h1;
            end
            if (moving && state_d == MSSP_ST_STOPPED) begin
                wait_on_q <= 1'b1;
                wait_q    <= 64'h0;
            end
            wr_q <= wr_fire;
            if (wr_fire) wr_busy_q <= 1'b1;
            else if (nvm_done) wr_busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // drive stage command
    // ------------------------------------------------------------------
    mssp_ramp #(
        .RAMP_MS (RAMP_MS)
    ) u_ramp (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (ramp_start),
        .clear   (ramp_clear),
        .target  (speed_set),
        .speed   (ramp_speed),
        .done    (ramp_done)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drive_q <= '0;
        end else if (ramp_clear || state_d == MSSP_ST_STOPPED ||
                     state_d == MSSP_ST_OFF) begin
            drive_q <= '0;
        end else if (state_d == MSSP_ST_HOLD) begin
            drive_q <= '{enable: 1'b1, forward_direction: dir_q,
                         speed: speed_set};
        end else if (state_d == MSSP_ST_RAMP) begin
            drive_q <= '{enable: 1'b1,
                         forward_direction: ramp_start ? fwd_s : dir_q,
                         speed: ramp_start ? `MSSP_SPD_RST :
                                ramp_speed};
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [`MSSP_POS_W-1:0] wr_data_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) wr_data_q <= `MSSP_POS_RST;
        else if (wr_fire) wr_data_q <= pos_q;
    end

    assign nvm_wr          = '{wr: wr_q, data: wr_data_q};
    assign drive           = drive_q;
    assign position        = pos_q;
    assign limit_acquire   = acq_q;
    assign standby_allowed = stby_q;
    assign off_ready       = off_q;

endmodule

// ===== testbench/mssp_seq_assertions.sv
/* mssp_seq_assertions.sv - port checks of the motor sequencer.
   assumes: bound to mssp_seq; one clock, async reset. */
`timescale 1ns/1ps

module mssp_seq_assertions
    import mssp_pkg::*;
#(
    parameter longint unsigned STORE_DELAY = 50
) (
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         rst,
    // commands
    input wire logic         run_cmd,
    input wire logic         forward_direction,
    input wire logic         shutdown_req,
    input wire logic         reversible_mode,
    input wire logic [15:0]  speed_set,
    // memory
    input wire logic [31:0]  restore_data,
    input wire logic         restore_valid,
    input wire logic         nvm_done,
    input wire mssp_nvm_wr_s nvm_wr,
    // drive and status
    input wire mssp_drive_s  drive,
    input wire logic [31:0]  position,
    input wire logic         standby_allowed,
    input wire logic         off_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // cycles spent with the drive off, saturating
    longint unsigned off_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) off_q <= '0;
        else if (drive.enable) off_q <= '0;
        else if (off_q < STORE_DELAY + 8) off_q <= off_q + 1;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_stop_halts: assert property ((!run_cmd && !reversible_mode)[*5]
        |-> !drive.enable && drive.speed == 16'h0) else $error("drive on");
    a_ramp_zero: assert property ($rose(drive.enable)
        |-> drive.speed <= 16'h1) else $error("ramp not from rest");
    a_start_dir: assert property ($rose(drive.enable)
        |-> drive.forward_direction == forward_direction) else $error("dir");
    a_hold_speed: assert property (drive.enable && $stable(speed_set)
        && drive.speed == speed_set |=> !drive.enable || $changed(drive.
        forward_direction) || drive.speed == speed_set) else $error("hold");
    a_ramp_step: assert property (drive.enable && $past(drive.enable)
        |-> drive.speed <= $past(drive.speed) + 16'h1) else $error("step");
    a_shut_halts: assert property ($rose(shutdown_req)
        |-> ##[1:6] !drive.enable) else $error("shutdown left drive on");
    a_store_idle: assert property (nvm_wr.wr
        |-> !drive.enable) else $error("store while running");
    a_store_data: assert property (nvm_wr.wr
        |-> nvm_wr.data == position) else $error("stored wrong value");
    a_store_delay: assert property (nvm_wr.wr && !shutdown_req
        |-> off_q >= STORE_DELAY - 3 && off_q <= STORE_DELAY + 3)
        else $error("store at wrong time");
    a_off_done: assert property ($rose(off_ready)
        |-> $past(nvm_done)) else $error("off before store done");
    a_restore: assert property ($rose(restore_valid)
        |-> ##[1:4] position == restore_data) else $error("no restore");
    a_no_standby: assert property (reversible_mode
        && $past(restore_valid) |-> !standby_allowed)
        else $error("standby in reversible mode");

    c_hold: cover property (drive.enable && drive.speed == speed_set);
    c_store: cover property (nvm_wr.wr && !shutdown_req);
    c_off: cover property ($rose(off_ready));
endmodule

bind mssp_seq mssp_seq_assertions #(.STORE_DELAY(STORE_DELAY)) chk_u (
    .clk_sys, .rst, .run_cmd, .forward_direction, .shutdown_req,
    .reversible_mode, .speed_set, .restore_data, .restore_valid,
    .nvm_done, .nvm_wr, .drive, .position, .standby_allowed, .off_ready);

// ===== testbench/mssp_nvm_model.sv
/* mssp_nvm_model.sv - nonvolatile position memory beside the sequencer.
   assumes: one write pulse at a time; contents survive rst. */
`timescale 1ns/1ps

module mssp_nvm_model
    import mssp_pkg::*;
#(
    parameter logic [31:0] INIT_POS = 32'h0000_1234
) (
    // clock and reset
    input wire logic          clk_sys,
    input wire logic          rst,
    // long write time when high
    input wire logic          slow,
    // sequencer side
    input wire mssp_nvm_wr_s  nvm_wr,
    output logic              nvm_done,
    output logic              restore_valid,
    output logic [31:0]       restore_data,
    output logic [31:0]       stored
);
    logic [31:0] mem_q = INIT_POS;
    logic [4:0]  busy_q;
    logic [3:0]  boot_q;

    // lines not yet valid show the inverse, never a usable copy
    assign restore_valid = (boot_q == 4'hf);
    assign restore_data  = restore_valid ? mem_q : ~mem_q;
    assign stored        = mem_q;

    always_ff @(posedge clk_sys) begin
        if (nvm_wr.wr) mem_q <= nvm_wr.data;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q   <= 5'h0;
            boot_q   <= 4'h0;
            nvm_done <= 1'b0;
        end else begin
            nvm_done <= (busy_q == 5'h1);
            if (nvm_wr.wr) busy_q <= slow ? 5'h14 : 5'h2;
            else if (busy_q != 5'h0) busy_q <= busy_q - 5'h1;
            if (!restore_valid) boot_q <= boot_q + 4'h1;
        end
    end
endmodule

// ===== testbench/test_motor_start_stop_position_store.sv
/* test_motor_start_stop_position_store.sv - self-checking bench of the
   motor sequencer: start, stop, reverse, position store, shutdown.
   assumes: mssp_pkg, mssp_seq and mssp_nvm_model compiled first. */
`timescale 1ns/1ps

module test_motor_start_stop_position_store
    import mssp_pkg::*;
;

    logic         clk_sys = 1'b0, rst = 1'b1, run_cmd = 1'b0;
    logic         forward_direction = 1'b1, shutdown_req = 1'b0;
    logic         reversible_mode = 1'b0, slow = 1'b0;
    logic         pos_step = 1'b0, pos_up = 1'b0;
    logic [15:0]  speed_set = 16'h0;
    logic [31:0]  restore_data, stored, position;
    logic         restore_valid, nvm_done, limit_acquire;
    logic         standby_allowed, off_ready;
    mssp_nvm_wr_s nvm_wr;
    mssp_drive_s  drive;
    int           fail_count = 0, n_checks = 0, wr_seen = 0, i, n0;
    int           exp_pos = 32'h1234;

    mssp_seq #(.RAMP_MS(0), .STORE_DELAY(50)) dut_u (
        .clk_sys, .rst, .run_cmd, .forward_direction, .shutdown_req,
        .reversible_mode, .speed_set, .pos_step, .pos_up, .restore_data,
        .restore_valid, .nvm_done, .nvm_wr, .drive, .position,
        .limit_acquire, .standby_allowed, .off_ready);
    mssp_nvm_model nvm_u (.clk_sys, .rst, .slow, .nvm_wr, .nvm_done,
        .restore_valid, .restore_data, .stored);

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (nvm_wr.wr === 1'b1) wr_seen++;
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // 0: setpoint held, 1: a store seen since n, 2: shutdown finished
    function automatic bit cond(int k, int n);
        case (k)
            0: return drive.enable === 1'b1 && drive.speed === speed_set;
            1: return wr_seen > n;
            default: return off_ready === 1'b1;
        endcase
    endfunction

    task automatic wait_on(int k, int n);
        for (i = 0; i < 300 && !cond(k, n); i++) cyc(1);
        if (i == 300) begin
            fail_count++;
            end_of_test();
        end
    endtask

    task automatic start(bit dir);
        speed_set <= 16'h8 + 16'($urandom % 24);
        forward_direction <= dir;
        run_cmd <= 1'b1;
        wait_on(0, 0);
    endtask

    task automatic steps(int n, bit up);
        repeat (n) begin
            pos_step <= 1'b1;
            pos_up   <= up;
            cyc(1);
            pos_step <= 1'b0;
            cyc(1);
        end
        exp_pos += up ? n : -n;
    endtask

    task automatic stop_store();
        n0 = wr_seen;
        run_cmd <= 1'b0;
        cyc(5);
        chk("drive", {14'h0, drive}, 32'h0);
        wait_on(1, n0);
        cyc(1);
        chk("stored", stored, exp_pos);
    endtask

    initial begin
        void'($urandom(32'h8473));
        cyc(6);
        rst <= 1'b0;
        cyc(30);
        chk("restore", position, exp_pos);
        chk("standby on", standby_allowed, 1'b1);
        for (int d = 1; d >= 0; d--) begin
            start(d[0]);
            cyc(5);
            chk("hold", drive.speed, speed_set);
            chk("dir", drive.forward_direction, d[0]);
            forward_direction <= !d[0];
            cyc(6);
            chk("reramp", drive.speed < speed_set, 1'b1);
            wait_on(0, 0);
            chk("newdir", drive.forward_direction, !d[0]);
            steps(1 + $urandom % 9, 1'($urandom % 2));
            stop_store();
        end
        start(1'b1);
        steps(3, 1'b1);
        n0 = wr_seen;
        run_cmd <= 1'b0;
        cyc(25);
        run_cmd <= 1'b1;
        cyc(40);
        chk("cancel", wr_seen, n0);
        stop_store();
        start(1'b0);
        n0 = wr_seen;
        run_cmd <= 1'b0;
        cyc(120);
        chk("same pos", wr_seen, n0);
        slow <= 1'b1;
        start(1'b1);
        steps(2, 1'b0);
        shutdown_req <= 1'b1;
        cyc(6);
        chk("shut drive", drive.enable, 1'b0);
        wait_on(2, 0);
        chk("shut store", stored, exp_pos);
        rst <= 1'b1;
        shutdown_req <= 1'b0;
        run_cmd <= 1'b0;
        reversible_mode <= 1'b1;
        speed_set <= 16'h28;
        cyc(6);
        rst <= 1'b0;
        cyc(24);
        chk("restore2", position, exp_pos);
        chk("acquire", limit_acquire, 1'b1);
        chk("standby", standby_allowed, 1'b0);
        wait_on(0, 0);
        chk("forced run", drive.enable, 1'b1);
        cyc(3);
        chk("acq done", limit_acquire, 1'b0);
        end_of_test();
    end
endmodule
